// file: design/aos_defs.vh
// offsets, field positions, reset values and counts for the
// output serializer; included by the gain and serializer design files of the block
`ifndef AOS_DEFS_VH
`define AOS_DEFS_VH

// register byte offsets on the bus
`define AOS_OFS_FMT      8'h00
`define AOS_OFS_DRV      8'h04
`define AOS_OFS_PAT_LO   8'h08
`define AOS_OFS_PAT_HI   8'h0c
`define AOS_OFS_GAIN     8'h10
`define AOS_OFS_RANGE    8'h14
`define AOS_OFS_STATUS   8'h18

// output_format_control fields
`define AOS_FMT_EQ       4
`define AOS_FMT_CODING   3
`define AOS_FMT_MSB      2
`define AOS_FMT_PAT_HI   1
`define AOS_FMT_PAT_LO   0
`define AOS_FMT_RST      8'h00
`define AOS_DRV_RST      8'h00

// gain control fields and automatic coefficient pairs
`define AOS_GAIN_OVR     7
`define AOS_GAIN_RST     8'h36
`define AOS_COEF_A_FULL  3'h7
`define AOS_COEF_B_FULL  3'h6
`define AOS_COEF_A_RED   3'h2
`define AOS_COEF_B_RED   3'h2
`define AOS_DGF_BASE     7'h20
`define AOS_DGF_DIV      19'sh0001a

// pattern select codes and fixed training words
`define AOS_PAT_DATA     2'h0
`define AOS_PAT_FIX1     2'h1
`define AOS_PAT_CUSTOM   2'h2
`define AOS_PAT_FIX2     2'h3
`define AOS_TRAIN1       12'h03f
`define AOS_TRAIN2       12'ha5a

// serial framing: bits per word and word clock high time in bits
`define AOS_WORD_BITS    4'hc
`define AOS_WORD_LAST    4'hb
`define AOS_WCLK_HIGH    4'h6

`endif

// file: design/aos_fifo.v
// synchronous valid/ready fifo between the gain stage and serializer
// assumes one clock, clock enable freezes it, async low reset
`timescale 1ns/1ps
module aos_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 16
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    // fill level
    output wire [$clog2(DEPTH):0] level
);
    localparam AW = $clog2(DEPTH);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];
    assign level = cnt_q;

    always @(posedge hclk) begin
        if (ce && push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

// file: design/aos_gain.v
// equalizer, digital gain and output coding for filter samples
// one register stage with valid/ready; stalls when downstream stalls
`timescale 1ns/1ps
`include "aos_defs.vh"
module aos_gain (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // configuration
    input wire equalizer_on,
    input wire output_coding_select,
    input wire gain_override,
    input wire reduced_input_range,
    input wire [2:0] coef_a,
    input wire [2:0] coef_b,
    // filter samples in, signed
    input wire in_valid,
    output wire in_ready,
    input wire [11:0] in_data,
    // coded samples out
    output wire out_valid,
    input wire out_ready,
    output wire [11:0] out_data
);
    // unused codes 011 -> +2, 100/101 -> -2
    function signed [2:0] coef_val;
        input [2:0] c;
        begin
            case (c)
                3'h0: coef_val = 3'sd0;
                3'h1: coef_val = 3'sd1;
                3'h2, 3'h3: coef_val = 3'sd2;
                3'h7: coef_val = -3'sd1;
                default: coef_val = -3'sd2;
            endcase
        end
    endfunction

    function [11:0] sat12;
        input signed [18:0] v;
        begin
            if (v > 19'sd2047)
                sat12 = 12'h7ff;
            else if (v < -19'sd2048)
                sat12 = 12'h800;
            else
                sat12 = v[11:0];
        end
    endfunction

    reg valid_q;
    reg [11:0] data_q;
    reg [11:0] prev_q;

    wire take = in_valid & in_ready;
    wire [2:0] a_sel;
    wire [2:0] b_sel;
    wire signed [6:0] gain_factor;
    wire signed [18:0] x;
    wire signed [18:0] xp;
    wire signed [18:0] eq;
    wire signed [18:0] prod;
    wire signed [18:0] quot;
    wire [11:0] scaled;
    wire [2:0] cb;
    wire [11:0] eqs;

    assign in_ready = !valid_q || out_ready;
    assign out_valid = valid_q;
    assign out_data = data_q;

    assign a_sel = gain_override ? coef_a :
        (reduced_input_range ? `AOS_COEF_A_RED : `AOS_COEF_A_FULL);
    assign b_sel = gain_override ? coef_b :
        (reduced_input_range ? `AOS_COEF_B_RED : `AOS_COEF_B_FULL);
    assign cb = coef_val(b_sel);
    // dgf = 32 + 4a + b, gain = dgf/26
    assign gain_factor = $signed(`AOS_DGF_BASE) + $signed({coef_val(a_sel), 2'b00})
        + $signed({{4{cb[2]}}, cb});

    assign x = {{7{in_data[11]}}, in_data};
    assign xp = {{7{prev_q[11]}}, prev_q};
    // sharpening tap trades power for less group delay
    assign eq = equalizer_on ? (x + ((x - xp) >>> 1)) : x;
    assign eqs = sat12(eq);
    assign prod = $signed({{7{eqs[11]}}, eqs}) * gain_factor;
    assign quot = prod / `AOS_DGF_DIV;
    assign scaled = sat12(quot);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            valid_q <= 1'b0;
            data_q <= 12'h000;
            prev_q <= 12'h000;
        end else if (ce) begin
            if (in_ready)
                valid_q <= in_valid;
            if (take) begin
                prev_q <= in_data;
                // offset binary flips the sign bit
                data_q <= {scaled[11] ^ output_coding_select,
                    scaled[10:0]};
            end
        end
    end
endmodule

// file: design/aos_serializer.v
// output formatting and serializer of the converter with an
// ahb-lite register slave. assumes a zero-wait single-word master,
// filter samples on hclk, and a link clock pin sampled by hclk.
// Contract
// - equalizer control set inserts equalizer; cleared bypasses it
// - coding select 0 gives two's complement, 1 offset binary
// - bit order 0 sends lsb first, 1 sends msb first
// - pattern select zero serializes twelve-bit filter samples
// - nonzero pattern select repeats chosen training word continuously
// - two training words fixed; third from the custom pattern registers
// - bit clock and word clock unaffected by pattern select
// - code 01 sends first fixed training word 000000111111
// - code 10 sends the custom user training word
// - gain follows coefficient pair; 111/110 is 0 db default
// - custom coefficients only apply while gain override is set
// - coefficients decode as signed steps, unused codes clamp to +-2
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "aos_defs.vh"
module aos_serializer #(
    parameter FIFO_DEPTH = 16
) (
    // clock, enable, reset
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    // filter samples
    input wire sample_valid,
    output wire sample_ready,
    input wire [11:0] sample_data,
    // link
    input wire link_clk_in,
    output wire ser_data,
    output wire ser_bit_clk,
    output wire ser_word_clk,
    // output driver settings
    output wire drv_term_en,
    output wire [1:0] drv_current,
    output wire output_common_level,
    output wire low_swing_signalling_select
);
    localparam LW = $clog2(FIFO_DEPTH) + 1;

    function [11:0] pick_word;
        input [1:0] sel;
        input [11:0] sample;
        input [11:0] custom;
        begin
            case (sel)
                `AOS_PAT_DATA: pick_word = sample;
                `AOS_PAT_FIX1: pick_word = `AOS_TRAIN1;
                `AOS_PAT_CUSTOM: pick_word = custom;
                default: pick_word = `AOS_TRAIN2;
            endcase
        end
    endfunction

    function pick_bit;
        input [11:0] w;
        input [3:0] idx;
        input msb_first;
        begin
            if (msb_first)
                pick_bit = w[`AOS_WORD_LAST - idx];
            else
                pick_bit = w[idx];
        end
    endfunction

    // registers
    reg [7:0] fmt_q;
    reg [7:0] fmt_d;
    reg [7:0] drv_q;
    reg [7:0] drv_d;
    reg [7:0] pat_lo_q;
    reg [7:0] pat_lo_d;
    reg [3:0] pat_hi_q;
    reg [3:0] pat_hi_d;
    reg [7:0] gain_q;
    reg [7:0] gain_d;
    reg range_q;
    reg range_d;

    // bus state
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    reg [31:0] hrdata_q;
    reg [31:0] rd_d;

    // link and serializer state
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg lvl_q;
    reg [3:0] idx_q;
    reg [11:0] word_q;
    reg msb_q;
    reg data_q;
    reg bclk_q;
    reg wclk_q;
    reg [15:0] words_q;
    reg [7:0] under_q;

    wire addr_take = hsel & hready & htrans[1];
    wire [7:0] a_lo = haddr[7:0];
    wire [11:0] custom = {pat_hi_q, pat_lo_q};
    wire [1:0] pattern_select = fmt_q[`AOS_FMT_PAT_HI:`AOS_FMT_PAT_LO];

    wire g_valid;
    wire g_ready;
    wire [11:0] g_data;
    wire f_valid;
    wire f_ready;
    wire [11:0] f_data;
    wire [LW-1:0] f_level;

    wire edge_rise = (s2_q == s3_q) && s3_q && !lvl_q;
    wire last_bit = (idx_q == `AOS_WORD_LAST);
    wire load = edge_rise && last_bit;
    wire [3:0] idx_d = last_bit ? 4'h0 : idx_q + 4'h1;
    wire [11:0] word_d = pick_word(pattern_select,
        f_valid ? f_data : 12'h000, custom);
    wire msb_d = fmt_q[`AOS_FMT_MSB];

    // always ready: every access completes in the data phase cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // fifo drained once per word, also while training words go out,
    // so the source never stalls behind a training period
    assign f_ready = load;

    assign ser_data = data_q;
    assign ser_bit_clk = bclk_q;
    assign ser_word_clk = wclk_q;
    assign drv_term_en = drv_q[4];
    assign drv_current = drv_q[3:2];
    assign output_common_level = drv_q[1];
    assign low_swing_signalling_select = drv_q[0];

    aos_gain u_gain (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .equalizer_on(fmt_q[`AOS_FMT_EQ]),
        .output_coding_select(fmt_q[`AOS_FMT_CODING]),
        .gain_override(gain_q[`AOS_GAIN_OVR]),
        .reduced_input_range(range_q),
        .coef_a(gain_q[5:3]),
        .coef_b(gain_q[2:0]),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_data),
        .out_valid(g_valid),
        .out_ready(g_ready),
        .out_data(g_data)
    );

    aos_fifo #(
        .WIDTH(12),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .in_valid(g_valid),
        .in_ready(g_ready),
        .in_data(g_data),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data),
        .level(f_level)
    );

    // write data phase updates the register next values
    always @* begin
        fmt_d = fmt_q;
        drv_d = drv_q;
        pat_lo_d = pat_lo_q;
        pat_hi_d = pat_hi_q;
        gain_d = gain_q;
        range_d = range_q;
        if (wr_pend_q) begin
            case (wr_addr_q)
                `AOS_OFS_FMT: fmt_d = {3'h0, hwdata[4:0]};
                `AOS_OFS_DRV: drv_d = {3'h0, hwdata[4:0]};
                `AOS_OFS_PAT_LO: pat_lo_d = hwdata[7:0];
                `AOS_OFS_PAT_HI: pat_hi_d = hwdata[3:0];
                `AOS_OFS_GAIN: gain_d = {hwdata[7], 1'b0, hwdata[5:0]};
                `AOS_OFS_RANGE: range_d = hwdata[0];
                default: fmt_d = fmt_q;
            endcase
        end
    end

    // read mux sees a write still in its data phase
    always @* begin
        rd_d = 32'h00000000;
        case (a_lo)
            `AOS_OFS_FMT: rd_d = {24'h000000, fmt_d};
            `AOS_OFS_DRV: rd_d = {24'h000000, drv_d};
            `AOS_OFS_PAT_LO: rd_d = {24'h000000, pat_lo_d};
            `AOS_OFS_PAT_HI: rd_d = {28'h0000000, pat_hi_d};
            `AOS_OFS_GAIN: rd_d = {24'h000000, gain_d};
            `AOS_OFS_RANGE: rd_d = {31'h00000000, range_d};
            `AOS_OFS_STATUS: rd_d = {words_q, under_q,
                {(8-LW){1'b0}}, f_level};
            default: rd_d = 32'h00000000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fmt_q <= `AOS_FMT_RST;
            drv_q <= `AOS_DRV_RST;
            pat_lo_q <= 8'h00;
            pat_hi_q <= 4'h0;
            gain_q <= `AOS_GAIN_RST;
            range_q <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h00000000;
        end else if (ce) begin
            fmt_q <= fmt_d;
            drv_q <= drv_d;
            pat_lo_q <= pat_lo_d;
            pat_hi_q <= pat_hi_d;
            gain_q <= gain_d;
            range_q <= range_d;
            wr_pend_q <= addr_take & hwrite;
            if (addr_take)
                wr_addr_q <= a_lo;
            if (addr_take && !hwrite)
                hrdata_q <= rd_d;
        end
    end

    // link clock pin: three flops, a change counts when two and three agree
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
        end else if (ce) begin
            s1_q <= link_clk_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                lvl_q <= s3_q;
        end
    end

    // serializer; first edge after reset loads a word
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_q <= `AOS_WORD_LAST;
            word_q <= 12'h000;
            msb_q <= 1'b0;
            data_q <= 1'b0;
            bclk_q <= 1'b0;
            wclk_q <= 1'b0;
            words_q <= 16'h0000;
            under_q <= 8'h00;
        end else if (ce) begin
            // clocks follow the link regardless of pattern
            bclk_q <= (s2_q == s3_q) ? s3_q : lvl_q;
            if (edge_rise) begin
                idx_q <= idx_d;
                wclk_q <= (idx_d < `AOS_WCLK_HIGH);
                if (load) begin
                    // training words repeat on every word
                    word_q <= word_d;
                    msb_q <= msb_d;
                    data_q <= pick_bit(word_d, 4'h0, msb_d);
                    words_q <= words_q + 16'h0001;
                    if (!f_valid && pattern_select == `AOS_PAT_DATA &&
                        under_q != 8'hff)
                        under_q <= under_q + 8'h01;
                end else begin
                    data_q <= pick_bit(word_q, idx_d, msb_q);
                end
            end
        end
    end
endmodule

// file: dv/aos_capture_model.sv
// capture logic model: rebuilds words, first bit ends in bit 11
// assumes data stable at the falling bit clock
`timescale 1ns/1ps
module aos_capture_model (
    // link
    input wire rst_n,
    input wire ser_data,
    input wire ser_bit_clk,
    input wire ser_word_clk,
    // captured word
    output reg [11:0] word_q,
    output reg valid_q
);
    reg [11:0] sh_q;
    reg [3:0] idx_q;
    reg wc_q;
    always @(negedge ser_bit_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_q <= 12'h000;
            valid_q <= 1'b0;
            sh_q <= 12'h000;
            idx_q <= 4'h0;
            wc_q <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            wc_q <= ser_word_clk;
            // word clock rise marks the first bit
            if (ser_word_clk & ~wc_q) begin
                sh_q <= {11'h000, ser_data};
                idx_q <= 4'h1;
            end else if (idx_q != 4'h0) begin
                sh_q <= {sh_q[10:0], ser_data};
                idx_q <= (idx_q == 4'hb) ? 4'h0 : idx_q + 4'h1;
                if (idx_q == 4'hb) begin
                    word_q <= {sh_q[10:0], ser_data};
                    valid_q <= 1'b1;
                end
            end
        end
    end
endmodule

// file: dv/aos_serializer_monitor.sv
// assertion checker for the serializer ports
// assumes one hclk domain; bound onto aos_serializer
`timescale 1ns/1ps
module aos_serializer_monitor #(
    parameter FIFO_DEPTH = 16
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    // samples and link
    input wire sample_valid,
    input wire sample_ready,
    input wire link_clk_in,
    input wire ser_data,
    input wire ser_bit_clk,
    input wire ser_word_clk
);
    reg bclk_q, wclk_q, seen_q, ph_v_q, ph_w_q;
    reg [7:0] ph_a_q, fmt_q, gain_q;
    reg [3:0] nbits_q;
    wire start = ser_word_clk & ~wclk_q;
    // shadows of written registers, so reads are judged by writes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bclk_q <= 1'b0;
            wclk_q <= 1'b0;
            seen_q <= 1'b0;
            ph_v_q <= 1'b0;
            ph_w_q <= 1'b0;
            ph_a_q <= 8'h00;
            fmt_q <= 8'h00;
            gain_q <= 8'h36;
            nbits_q <= 4'h0;
        end else begin
            bclk_q <= ser_bit_clk;
            wclk_q <= ser_word_clk;
            if (ser_bit_clk & ~bclk_q) begin
                nbits_q <= start ? 4'h1 : nbits_q + 4'h1;
                seen_q <= seen_q | start;
            end
            if (ce) begin
                ph_v_q <= hsel & hready & htrans[1];
                ph_w_q <= hwrite;
                ph_a_q <= haddr[7:0];
                if (ph_v_q & ph_w_q & (ph_a_q == 8'h00))
                    fmt_q <= hwdata[7:0];
                if (ph_v_q & ph_w_q & (ph_a_q == 8'h10))
                    gain_q <= hwdata[7:0];
            end
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    property p_bclk_follow;
        $rose(link_clk_in) |-> ##[1:6] $rose(ser_bit_clk);
    endproperty
    a_bclk_follow: assert property (p_bclk_follow)
        else $error("bit clock missed a link clock rise");
    property p_bclk_low;
        !link_clk_in [*8] |-> !ser_bit_clk;
    endproperty
    a_bclk_low: assert property (p_bclk_low)
        else $error("bit clock high while link clock stopped");
    property p_data_edge;
        $changed(ser_data) |-> $rose(ser_bit_clk);
    endproperty
    a_data_edge: assert property (p_data_edge)
        else $error("serial data moved off a bit boundary");
    property p_wclk_edge;
        $changed(ser_word_clk) |-> $rose(ser_bit_clk);
    endproperty
    a_wclk_edge: assert property (p_wclk_edge)
        else $error("word clock moved off a bit boundary");
    property p_wclk_high;
        (wclk_q && !ser_word_clk) |-> nbits_q == 4'h6;
    endproperty
    a_wclk_high: assert property (p_wclk_high)
        else $error("word clock high time not six bits");
    property p_word_len;
        (start && seen_q) |-> nbits_q == 4'hc;
    endproperty
    a_word_len: assert property (p_word_len)
        else $error("word length not twelve bits");
    property p_fmt_rd;
        (ph_v_q && !ph_w_q && ph_a_q == 8'h00) |-> hrdata[4:0] == fmt_q[4:0];
    endproperty
    a_fmt_rd: assert property (p_fmt_rd)
        else $error("format control read back wrong");
    property p_gain_rd;
        (ph_v_q && !ph_w_q && ph_a_q == 8'h10)
            |-> hrdata[7:0] == {gain_q[7], 1'b0, gain_q[5:0]};
    endproperty
    a_gain_rd: assert property (p_gain_rd)
        else $error("gain control read back wrong");
    c_word: cover property (start && seen_q);
    c_refuse: cover property (sample_valid && !sample_ready);
    c_fmt_rd: cover property (ph_v_q && !ph_w_q && ph_a_q == 8'h00);
endmodule
bind aos_serializer aos_serializer_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .link_clk_in(link_clk_in),
    .ser_data(ser_data), .ser_bit_clk(ser_bit_clk),
    .ser_word_clk(ser_word_clk));

// file: dv/aos_serializer_test.sv
// bench: bus master, sample driver, framed link clock, word compare
// assumes capture model and checker compiled first
`timescale 1ns/1ps
`include "aos_defs.vh"
module aos_serializer_test;
    reg hclk, hresetn, hsel, hwrite, sample_valid, link_clk_in, ce;
    reg [31:0] haddr, hwdata, rd;
    reg [1:0] htrans;
    reg [11:0] sample_data;
    wire hreadyout, hresp, sample_ready, ser_data, ser_bit_clk;
    wire ser_word_clk, cap_valid;
    wire [31:0] hrdata;
    wire [4:0] drv;
    wire [11:0] cap_word;
    logic [11:0] exp_q[$];
    logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h1c};
    logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h36, 8'h00, 8'h00};
    // range, format control, gain control
    logic [16:0] cf[6] = '{{1'b0, 16'h0036}, {1'b1, 16'h0c00},
        {1'b0, 16'h149d}, {1'b0, 16'h04a1}, {1'b1, 16'h1c87}, 17'h0};
    int n_fail, cmp_count, prev, x;
    aos_serializer dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_data(sample_data), .link_clk_in(link_clk_in),
        .ser_data(ser_data), .ser_bit_clk(ser_bit_clk),
        .ser_word_clk(ser_word_clk), .drv_term_en(drv[4]),
        .drv_current(drv[3:2]), .output_common_level(drv[1]),
        .low_swing_signalling_select(drv[0]));
    aos_capture_model cap (.rst_n(hresetn), .ser_data(ser_data),
        .ser_bit_clk(ser_bit_clk), .ser_word_clk(ser_word_clk),
        .word_q(cap_word), .valid_q(cap_valid));
    task check(input string nm, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("resp", hresp, 1'b0);
    endtask
    task push(input logic [11:0] v);
        @(posedge hclk);
        sample_valid <= 1'b1;
        sample_data <= v;
        do @(posedge hclk); while (sample_ready !== 1'b1);
        sample_valid <= 1'b0;
    endtask
    // link clock runs only within frames; offset keeps it off hclk edges
    task frames(input int n);
        #7;
        repeat (12 * n) begin
            #80 link_clk_in = 1'b1;
            #80 link_clk_in = 1'b0;
        end
        repeat (10) @(posedge hclk);
        check("pending", exp_q.size(), 0);
    endtask
    function automatic int sat(input int v);
        return v > 2047 ? 2047 : (v < -2048 ? -2048 : v);
    endfunction
    function automatic int dec(input logic [2:0] c);
        case (c)
            3'b000: return 0;
            3'b001: return 1;
            3'b111: return -1;
            3'b010, 3'b011: return 2;
            default: return -2;
        endcase
    endfunction
    function automatic logic [11:0] order(logic [11:0] w, logic msb);
        logic [11:0] r;
        for (int i = 0; i < 12; i++) r[i] = w[11 - i];
        return msb ? w : r;
    endfunction
    function automatic logic [11:0] coded(int v, p, logic [16:0] c);
        int y, k;
        y = c[12] ? sat(v + ((v - p) >>> 1)) : v;
        k = c[7] ? 32 + 4 * dec(c[5:3]) + dec(c[2:0]) : (c[16] ? 42 : 26);
        y = sat(y * k / 26);
        return order(12'(y) ^ {c[11], 11'h0}, c[10]);
    endfunction
    always @(posedge cap_valid) begin
        if (exp_q.size() == 0) check("extra", 1, 0);
        else check("word", cap_word, exp_q.pop_front());
    end
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    initial begin
        #400us;
        n_fail++;
        wrap_up;
    end
    initial begin
        logic [11:0] w;
        {hresetn, hsel, hwrite, sample_valid, link_clk_in} = 5'h0;
        ce = 1'b1;
        {haddr, hwdata, htrans, sample_data} = '0;
        n_fail = 0;
        cmp_count = 0;
        prev = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        void'($urandom(90));
        bus(1'b1, 8'h1c, 32'hffffffff);
        foreach (ra[i]) begin
            bus(1'b0, ra[i], 0);
            check("reset", rd, {24'h0, rv[i]});
        end
        bus(1'b1, 8'h04, 32'h1b);
        bus(1'b0, 8'h04, 0);
        check("drv", drv, 5'h1b);
        // enable low must freeze the register file
        ce <= 1'b0;
        bus(1'b1, 8'h04, 32'h0);
        ce <= 1'b1;
        bus(1'b0, 8'h04, 0);
        check("freeze", drv, 5'h1b);
        w = $urandom;
        bus(1'b1, 8'h08, w[7:0]);
        bus(1'b1, 8'h0c, w[11:8]);
        for (int s = 1; s < 4; s++)
            for (int m = 0; m < 2; m++) begin
                bus(1'b1, 8'h00, s | m << 2);
                repeat (2) exp_q.push_back(order(s == 1 ? `AOS_TRAIN1 :
                    (s == 2 ? w : `AOS_TRAIN2), m[0]));
                frames(2);
            end
        foreach (cf[i]) begin
            bus(1'b1, 8'h14, cf[i][16]);
            bus(1'b1, 8'h10, cf[i][7:0]);
            bus(1'b1, 8'h00, cf[i][15:8]);
            repeat (i == 5 ? 17 : 4) begin
                w = $urandom;
                x = $signed(w);
                push(w);
                exp_q.push_back(coded(x, prev, cf[i]));
                prev = x;
            end
            if (i == 5) begin
                @(posedge hclk);
                sample_valid <= 1'b1;
                repeat (4) @(posedge hclk);
                check("ready", sample_ready, 1'b0);
                sample_valid <= 1'b0;
                bus(1'b0, 8'h18, 0);
                check("level", rd[4:0], 5'h10);
                exp_q.push_back(12'h000);
            end
            frames(i == 5 ? 18 : 4);
        end
        bus(1'b0, 8'h18, 0);
        check("underflow", rd[15:8], 8'h01);
        wrap_up;
    end
    task wrap_up;
        if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
endmodule
